// File: src/store_pkg.sv
// Constants shared by the backed store access port and its write buffer.
package store_pkg;
    localparam int unsigned STORE_BYTES = 512;
    localparam int unsigned PTR_W = 9;
    localparam int unsigned REG_ADDR_W = 5;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned SYNC_STAGES = 3;
    localparam logic [4:0] STORE_POINTER_HIGH_OFS = 5'h1a;
    localparam logic [4:0] STORE_POINTER_LOW_OFS = 5'h1b;
    localparam logic [4:0] STORE_WRITE_PORT_OFS = 5'h1c;
    localparam logic [4:0] STORE_READ_PORT_OFS = 5'h1d;
    localparam logic [4:0] REG_WRAP_OFS = 5'h1b;
    localparam logic [4:0] REG_ADDR_RESET = 5'h00;
    localparam logic [8:0] POINTER_RESET = 9'h000;
    localparam int unsigned POINTER_TOP_BIT_POS = 0;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // Time one byte occupies the store array while it is written.
    localparam int unsigned STORE_WRITE_NS = 10;
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned STORE_WRITE_CYCLES =
        (STORE_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : store_pkg

// File: src/store_fifo.sv
// Parameterised first-in first-out buffer held in flip-flops.
`timescale 1ns/1ps
module store_fifo #(
    parameter int unsigned WIDTH = 17,
    parameter int unsigned DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
            $error("store_fifo: depth must be a power of two >= 2");
        end
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule : store_fifo

// File: src/backed_sram_access_port.sv
// Register access path into the battery-backed general-purpose store.
`timescale 1ns/1ps
module backed_sram_access_port #(
    parameter int unsigned WRITE_CYCLES = store_pkg::STORE_WRITE_CYCLES,
    parameter int unsigned BUF_DEPTH = store_pkg::FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic on_battery,
    input wire logic sel_strobe,
    input wire logic [4:0] sel_addr,
    input wire logic wr_strobe,
    input wire logic [7:0] wr_data,
    output logic wr_ready,
    input wire logic rd_strobe,
    output logic rd_ready,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic rd_data_oe
);
    localparam int unsigned ENTRY_W = store_pkg::PTR_W + store_pkg::DATA_W;

    initial begin
        if (WRITE_CYCLES < 1 || WRITE_CYCLES > 255) begin
            $error("backed_sram_access_port: WRITE_CYCLES out of range");
        end
    end

    // Battery indication arrives from the supply monitor, asynchronous.
    logic [2:0] batt_sync_q, batt_sync_d;
    logic batt_q, batt_d;

    always_comb begin
        batt_sync_d = {batt_sync_q[1:0], on_battery};
        batt_d = batt_q;
        if (batt_sync_q[1] == batt_sync_q[2]) begin
            batt_d = batt_sync_q[2];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            batt_sync_q <= 3'h0;
            batt_q <= 1'b0;
        end else begin
            batt_sync_q <= batt_sync_d;
            batt_q <= batt_d;
        end
    end

    // Register address and store pointer.
    logic [4:0] reg_addr_q, reg_addr_d;
    logic [8:0] store_word_pointer_q, store_word_pointer_d;
    logic [7:0] rd_data_q, rd_data_d;
    logic rd_valid_q, rd_valid_d;
    logic oe_q, oe_d;
    logic store_pointer_top_bit;
    logic [7:0] store_pointer_low_byte;

    logic buf_in_ready, buf_out_valid, buf_out_ready;
    logic [ENTRY_W-1:0] buf_out_data;
    logic wr_take, rd_take, sel_take, push;
    logic at_write_port, at_read_port;
    logic [7:0] store_q [store_pkg::STORE_BYTES];

    assign store_pointer_top_bit =
        store_word_pointer_q[store_pkg::PTR_W-1];
    assign store_pointer_low_byte = store_word_pointer_q[7:0];
    assign at_write_port = (reg_addr_q == store_pkg::STORE_WRITE_PORT_OFS);
    assign at_read_port = (reg_addr_q == store_pkg::STORE_READ_PORT_OFS);

    // While on battery every strobe is ignored and ready is withdrawn.
    assign sel_take = sel_strobe && !batt_q;
    assign wr_ready = !batt_q && !sel_strobe &&
        (!at_write_port || buf_in_ready);
    // A read waits until buffered writes have reached the store.
    assign rd_ready = !batt_q && !sel_strobe && !wr_strobe &&
        !buf_out_valid;
    assign wr_take = wr_strobe && wr_ready;
    assign rd_take = rd_strobe && rd_ready;
    assign push = wr_take && at_write_port;

    function automatic logic [4:0] next_reg(input logic [4:0] a);
        logic [4:0] n;
        n = 5'h00;
        if (a == store_pkg::STORE_WRITE_PORT_OFS ||
            a == store_pkg::STORE_READ_PORT_OFS) begin
            n = a;
        end else if (a >= store_pkg::REG_WRAP_OFS) begin
            n = store_pkg::REG_ADDR_RESET;
        end else begin
            n = a + 5'h01;
        end
        return n;
    endfunction : next_reg

    always_comb begin
        reg_addr_d = reg_addr_q;
        store_word_pointer_d = store_word_pointer_q;
        rd_data_d = rd_data_q;
        rd_valid_d = 1'b0;
        oe_d = !batt_q;
        if (sel_take) begin
            reg_addr_d = sel_addr;
        end else if (wr_take) begin
            reg_addr_d = next_reg(reg_addr_q);
            unique case (reg_addr_q)
                store_pkg::STORE_POINTER_HIGH_OFS: begin
                    store_word_pointer_d[store_pkg::PTR_W-1] =
                        wr_data[store_pkg::POINTER_TOP_BIT_POS];
                end
                store_pkg::STORE_POINTER_LOW_OFS: begin
                    store_word_pointer_d[7:0] = wr_data;
                end
                store_pkg::STORE_WRITE_PORT_OFS: begin
                    store_word_pointer_d =
                        store_word_pointer_q + 9'h001;
                end
                default: begin
                end
            endcase
        end else if (rd_take) begin
            reg_addr_d = next_reg(reg_addr_q);
            rd_valid_d = 1'b1;
            unique case (reg_addr_q)
                store_pkg::STORE_POINTER_HIGH_OFS: begin
                    rd_data_d = {7'h00, store_pointer_top_bit};
                end
                store_pkg::STORE_POINTER_LOW_OFS: begin
                    rd_data_d = store_pointer_low_byte;
                end
                store_pkg::STORE_READ_PORT_OFS: begin
                    rd_data_d = store_q[store_word_pointer_q];
                    store_word_pointer_d =
                        store_word_pointer_q + 9'h001;
                end
                default: begin
                    rd_data_d = store_pkg::UNMAPPED_READ;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reg_addr_q <= store_pkg::REG_ADDR_RESET;
            store_word_pointer_q <= store_pkg::POINTER_RESET;
            rd_data_q <= 8'h00;
            rd_valid_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            reg_addr_q <= reg_addr_d;
            store_word_pointer_q <= store_word_pointer_d;
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            oe_q <= oe_d;
        end
    end

    assign rd_data = oe_q ? rd_data_q : 8'h00;
    assign rd_valid = rd_valid_q && oe_q;
    assign rd_data_oe = oe_q;

    // Each buffered entry carries its own store address and byte.
    store_fifo #(
        .WIDTH(ENTRY_W),
        .DEPTH(BUF_DEPTH)
    ) write_buf (
        .sys_clk(sys_clk),
        .reset(reset),
        .in_valid(push),
        .in_ready(buf_in_ready),
        .in_data({store_word_pointer_q, wr_data}),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out_data)
    );

    // The store accepts one byte per WRITE_CYCLES, so bursts back up.
    logic [7:0] wait_q, wait_d;
    logic commit;

    assign buf_out_ready = (wait_q == 8'h00);
    assign commit = buf_out_valid && buf_out_ready;

    always_comb begin
        wait_d = wait_q;
        if (commit) begin
            wait_d = 8'(WRITE_CYCLES - 1);
        end else if (wait_q != 8'h00) begin
            wait_d = wait_q - 8'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wait_q <= 8'h00;
        end else begin
            wait_q <= wait_d;
        end
    end

    // Store contents are not touched by reset so they survive it.
    always_ff @(posedge sys_clk) begin
        if (commit) begin
            store_q[buf_out_data[ENTRY_W-1:store_pkg::DATA_W]] <=
                buf_out_data[store_pkg::DATA_W-1:0];
        end
    end
endmodule : backed_sram_access_port

// File: verif/store_port_monitor.sv
// Port-level checker for the backed store access port.
`timescale 1ns/1ps
module store_port_monitor (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic on_battery,
    input wire logic sel_strobe,
    input wire logic [4:0] sel_addr,
    input wire logic wr_strobe,
    input wire logic wr_ready,
    input wire logic rd_strobe,
    input wire logic rd_ready,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic rd_data_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    wire logic rd_take = rd_strobe && rd_ready;
    property p_rd_ans; rd_take |=> rd_valid; endproperty
    a_rd_ans: assert property (p_rd_ans)
        else $error("read not answered next cycle");
    property p_rd_cause; rd_valid |-> $past(rd_take); endproperty
    a_rd_cause: assert property (p_rd_cause)
        else $error("read valid without a read");
    property p_sel_block; sel_strobe |-> !wr_ready && !rd_ready; endproperty
    a_sel_block: assert property (p_sel_block)
        else $error("transfer taken with a select");
    property p_batt;
        on_battery [*7] |-> !rd_data_oe && !wr_ready && !rd_ready;
    endproperty
    a_batt: assert property (p_batt)
        else $error("interface active on battery");
    property p_rel_zero; !rd_data_oe |-> rd_data == 8'h00; endproperty
    a_rel_zero: assert property (p_rel_zero)
        else $error("read data not cleared when released");
    property p_top_zero;
        sel_strobe && sel_addr == 5'h1a ##2 rd_take |=> rd_data[7:1] == 7'h00;
    endproperty
    a_top_zero: assert property (p_top_zero)
        else $error("pointer high upper bits not zero");
    property p_rd_hold;
        !rd_take && rd_data_oe |=> !rd_data_oe || $stable(rd_data);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data changed without a read");
    property p_wrap;
        sel_strobe && sel_addr == 5'h1b ##2 wr_strobe && wr_ready ##2 rd_take
            |=> rd_data == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("register address did not wrap to 00h");
endmodule : store_port_monitor
bind backed_sram_access_port store_port_monitor mon (
    .sys_clk(sys_clk),
    .reset(reset),
    .on_battery(on_battery),
    .sel_strobe(sel_strobe),
    .sel_addr(sel_addr),
    .wr_strobe(wr_strobe),
    .wr_ready(wr_ready),
    .rd_strobe(rd_strobe),
    .rd_ready(rd_ready),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .rd_data_oe(rd_data_oe)
);

// File: verif/store_host.sv
// Host model that drives the register select, write and read strobes.
`timescale 1ns/1ps
module store_host (
    input wire logic sys_clk,
    input wire logic wr_ready,
    input wire logic rd_ready,
    output logic sel_strobe,
    output logic [4:0] sel_addr,
    output logic wr_strobe,
    output logic [7:0] wr_data,
    output logic rd_strobe
);
    logic [7:0] exp_q[$];
    initial begin
        sel_strobe = 1'b0;
        sel_addr = 5'h00;
        wr_strobe = 1'b0;
        wr_data = 8'h00;
        rd_strobe = 1'b0;
    end
    // Released lines show the inverse so stale values cannot pass.
    task automatic sel(input logic [4:0] a);
        @(negedge sys_clk);
        sel_strobe = 1'b1;
        sel_addr = a;
        @(negedge sys_clk);
        sel_strobe = 1'b0;
        sel_addr = ~a;
    endtask : sel
    task automatic wr(input logic [7:0] d);
        @(negedge sys_clk);
        wr_strobe = 1'b1;
        wr_data = d;
        #1;
        while (wr_ready !== 1'b1) begin @(negedge sys_clk); #1; end
        @(negedge sys_clk);
        wr_strobe = 1'b0;
        wr_data = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] e);
        @(negedge sys_clk);
        rd_strobe = 1'b1;
        #1;
        while (rd_ready !== 1'b1) begin @(negedge sys_clk); #1; end
        exp_q.push_back(e);
        @(negedge sys_clk);
        rd_strobe = 1'b0;
    endtask : rd
endmodule : store_host

// File: verif/tb_backed_sram_access_port.sv
// Self-checking bench for the backed store access port.
`timescale 1ns/1ps
module tb_backed_sram_access_port;
    logic sys_clk, reset, on_battery, sel_strobe, wr_strobe, rd_strobe;
    logic wr_ready, rd_ready, rd_valid, rd_data_oe, seen_full;
    logic [4:0] sel_addr;
    logic [7:0] wr_data, rd_data;
    logic [7:0] ref_mem [24];
    int n_fail = 0, check_count = 0, cyc = 0, seed, i;
    initial begin sys_clk = 1'b0; forever #2.5 sys_clk = ~sys_clk; end
    // Slow store writes so the write buffer fills.
    backed_sram_access_port #(.WRITE_CYCLES(8), .BUF_DEPTH(16)) DUT (
        .sys_clk(sys_clk),
        .reset(reset),
        .on_battery(on_battery),
        .sel_strobe(sel_strobe),
        .sel_addr(sel_addr),
        .wr_strobe(wr_strobe),
        .wr_data(wr_data),
        .wr_ready(wr_ready),
        .rd_strobe(rd_strobe),
        .rd_ready(rd_ready),
        .rd_data(rd_data),
        .rd_valid(rd_valid),
        .rd_data_oe(rd_data_oe)
    );
    store_host host (
        .sys_clk(sys_clk),
        .wr_ready(wr_ready),
        .rd_ready(rd_ready),
        .sel_strobe(sel_strobe),
        .sel_addr(sel_addr),
        .wr_strobe(wr_strobe),
        .wr_data(wr_data),
        .rd_strobe(rd_strobe)
    );
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic ok);
        check_count++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("ERROR %0t: port state wrong", $time);
        end
    endtask : chk
    task automatic load(input logic [7:0] hi, input logic [7:0] lo);
        host.sel(5'h1a);
        host.wr(hi);
        host.wr(lo);
    endtask : load
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (wr_strobe && !wr_ready) seen_full <= 1'b1;
        if (rd_valid === 1'b1) begin
            check_count++;
            if (host.exp_q.size() == 0 || rd_data !== host.exp_q[0]) begin
                n_fail++;
                $display("ERROR %0t: read data %h", $time, rd_data);
            end
            if (host.exp_q.size() != 0) void'(host.exp_q.pop_front());
        end
        if (cyc == 4000) begin
            n_fail++;
            end_sim();
        end
    end
    initial begin
        seed = 52616;
        reset = 1'b1;
        on_battery = 1'b0;
        seen_full = 1'b0;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk) reset = 1'b0;
        host.sel(5'h1a);
        host.rd(8'h00);
        host.rd(8'h00);
        load(8'hff, 8'hf0);
        host.sel(5'h1c);
        for (i = 0; i < 24; i++) begin
            ref_mem[i] = 8'($random(seed));
            host.wr(ref_mem[i]);
        end
        chk(seen_full);
        host.sel(5'h1a);
        host.rd(8'h00);
        host.rd(8'h08);
        load(8'h01, 8'hf0);
        host.sel(5'h1d);
        for (i = 0; i < 24; i++) host.rd(ref_mem[i]);
        host.sel(5'h1b);
        host.wr(8'h55);
        host.rd(8'h00);
        @(negedge sys_clk) on_battery = 1'b1;
        repeat (8) @(negedge sys_clk);
        chk(rd_data_oe === 1'b0 && wr_ready === 1'b0);
        chk(rd_data === 8'h00);
        host.sel(5'h1b);
        on_battery = 1'b0;
        repeat (8) @(negedge sys_clk);
        chk(rd_data_oe === 1'b1);
        host.rd(8'h00);
        load(8'h01, 8'hf0);
        host.sel(5'h1d);
        host.rd(ref_mem[0]);
        repeat (4) @(negedge sys_clk);
        end_sim();
    end
endmodule : tb_backed_sram_access_port
